// ### verilog/fieldbus_master_poll_supervision.sv
`timescale 1ns/1ps
module fieldbus_master_poll_supervision
	import fieldbus_supervision_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// link engine side
	input wire poll_result_type poll_result,
	input wire logic token_pass,
	input wire logic fault,
	input wire logic [15:0] slave_min_interval,
	output logic poll_next,
	output logic poll_repeat,
	output logic probe_req,
	output logic [6:0] probe_addr,
	output logic master_reset,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// reset release and ticks

	logic rst_meta_q, rst_sync_n;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// ms and 0.1 ms tick sources
	// one divider per time base keeps timing rate independent
	logic [15:0] ms_div_q, sub_div_q;
	logic ms_tick, sub_tick;
	assign ms_tick = (ms_div_q == 16'(TICK_CYCLES - 1));
	assign sub_tick = (sub_div_q == 16'(SUB_CYCLES - 1));
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			ms_div_q <= 16'h0000;
			sub_div_q <= 16'h0000;
		end
		else
		begin
			ms_div_q <= ms_tick ? 16'h0000 : ms_div_q + 16'h0001;
			sub_div_q <= sub_tick ? 16'h0000 : sub_div_q + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	logic enable_q, auto_clear_q;
	logic [6:0] probe_addr_lim_q;
	logic [7:0] gap_q;
	logic [3:0] retry_q;
	logic [15:0] poll_to_q, dct_q, min_int_q, wd_q;
	logic [NSLAVE-1:0] wd_en_q;
	logic [NSTAT-1:0] status_q, mask_q, events;
	logic wr_go, aw_held_q, w_held_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;

	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

	// latch address and data in either order, answer once both are in
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q[1:0] == 2'b00 && aw_q <= ADDR_STATE)
					? 2'b00 : 2'b10;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	logic [31:0] wv;
	assign wv = w_q & {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};

	// configuration writes; fields clamp to their documented range
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			enable_q <= 1'b0;
			auto_clear_q <= 1'b0;
			probe_addr_lim_q <= PROBE_ADDR_RST;
			gap_q <= GAP_RST;
			retry_q <= RETRY_RST;
			poll_to_q <= POLL_TO_RST;
			dct_q <= DCT_RST;
			min_int_q <= MIN_INT_RST;
			wd_q <= WD_RST;
			wd_en_q <= '1;
			mask_q <= '0;
		end
		else if (wr_go)
		begin
			case (aw_q)
				ADDR_CTRL:
				begin
					enable_q <= wv[0];
					auto_clear_q <= wv[1];
				end
				ADDR_PROBE:
				begin
					if (wv[6:0] < PROBE_ADDR_MIN)
						probe_addr_lim_q <= PROBE_ADDR_MIN;
					else if (wv[6:0] > PROBE_ADDR_MAX)
						probe_addr_lim_q <= PROBE_ADDR_MAX;
					else
						probe_addr_lim_q <= wv[6:0];
					gap_q <= (wv[15:8] == 8'h00) ? 8'h01 : wv[15:8];
					if (wv[19:16] == 4'h0)
						retry_q <= 4'h1;
					else if (wv[19:16] > RETRY_MAX)
						retry_q <= RETRY_MAX;
					else
						retry_q <= wv[19:16];
				end
				ADDR_POLL_TO: poll_to_q <= wv[15:0];
				ADDR_DCT: dct_q <= wv[15:0];
				ADDR_MIN_INT: min_int_q <= (wv[15:0] == 16'h0000)
					? 16'h0001 : wv[15:0];
				ADDR_WD: wd_q <= (wv[15:0] == 16'h0000) ? 16'h0001 : wv[15:0];
				ADDR_WD_EN: wd_en_q <= wv[NSLAVE-1:0];
				ADDR_MASK: mask_q <= wv[NSTAT-1:0];
				default: ;
			endcase
		end
	end

	// sticky status; a new event wins over the write-one clear
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
			status_q <= '0;
		else if (wr_go && aw_q == ADDR_STATUS)
			status_q <= (status_q & ~wv[NSTAT-1:0]) | events;
		else
			status_q <= status_q | events;
	end

	assign irq = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////
	// poll sequencing

	poll_state_type state_q;
	logic [3:0] tries_q;
	logic [15:0] eff_int, gap_cnt_q;
	logic gap_done, retry_fail;

	// effective interval is the larger one
	assign eff_int = (slave_min_interval > min_int_q)
		? slave_min_interval : min_int_q;
	// the first sub-tick is a partial one, so count whole ticks after it;
	// the wait is never short, at the cost of up to one extra 0.1 ms
	assign gap_done = sub_tick && (gap_cnt_q >= eff_int);
	assign retry_fail = poll_result.done && poll_result.timeout
		&& (tries_q >= retry_q);

	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			state_q <= POLL_IDLE;
			tries_q <= 4'h0;
			gap_cnt_q <= 16'h0000;
			poll_next <= 1'b0;
			poll_repeat <= 1'b0;
		end
		else
		begin
			poll_next <= 1'b0;
			poll_repeat <= 1'b0;
			case (state_q)
				POLL_IDLE:
					if (enable_q)
					begin
						poll_next <= 1'b1;
						tries_q <= 4'h0;
						state_q <= POLL_WAIT_ANS;
					end
				POLL_WAIT_ANS:
					if (poll_result.done)
					begin
						if (poll_result.timeout && tries_q < retry_q)
						begin
							tries_q <= tries_q + 4'h1;
							poll_repeat <= 1'b1;
						end
						else if (poll_result.had_data)
						begin
							poll_next <= 1'b1;
							tries_q <= 4'h0;
						end
						else
						begin
							gap_cnt_q <= 16'h0000;
							state_q <= POLL_GAP;
						end
					end
				POLL_GAP:
					if (gap_done)
					begin
						poll_next <= 1'b1;
						tries_q <= 4'h0;
						state_q <= POLL_WAIT_ANS;
					end
					else if (sub_tick)
						gap_cnt_q <= gap_cnt_q + 16'h0001;
				default: state_q <= POLL_IDLE;
			endcase
			if (!enable_q)
				state_q <= POLL_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// probing for other masters

	logic [7:0] pass_cnt_q;
	logic sweep_done;
	logic [6:0] next_addr;
	assign sweep_done = probe_req && probe_addr >= probe_addr_lim_q;
	assign next_addr = (probe_addr >= probe_addr_lim_q)
		? 7'h00 : probe_addr + 7'h01;

	// probe sweep up to the limit
	// gap factor token passes between sweeps
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			probe_req <= 1'b0;
			probe_addr <= 7'h00;
			pass_cnt_q <= 8'h00;
		end
		else
		begin
			probe_req <= 1'b0;
			if (token_pass && enable_q)
			begin
				if (pass_cnt_q != 8'h00)
					pass_cnt_q <= pass_cnt_q - 8'h01;
				else
				begin
					probe_req <= 1'b1;
					probe_addr <= next_addr;
					// reload with the last probe, so a pass in the very
					// next cycle cannot slip a probe in before the gap
					if (next_addr >= probe_addr_lim_q)
						pass_cnt_q <= gap_q;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// millisecond supervision

	logic fault_exp, dct_exp, wd_live;
	logic [NSLAVE-1:0] wd_exp, seen;

	// self reset after a lasting fault
	ms_timer u_poll_to
	(
		.clk(ref_clk),
		.rst_n(rst_sync_n),
		.tick(ms_tick),
		.run(fault),
		.limit(poll_to_q),
		.expired(fault_exp)
	);
	assign master_reset = fault_exp;

	// data control window only in auto clear
	ms_timer u_dct
	(
		.clk(ref_clk),
		.rst_n(rst_sync_n),
		.tick(ms_tick),
		.run(auto_clear_q && enable_q && !(poll_result.done
			&& !poll_result.timeout)),
		.limit(dct_q),
		.expired(dct_exp)
	);

	// one presence watchdog per slave, restarted by any answer from that slave
	// disabled slaves never run their timer
	for (genvar i = 0; i < NSLAVE; i++)
	begin : g_wd
		assign seen[i] = poll_result.done && !poll_result.timeout
			&& poll_result.slave == 3'(i);
		ms_timer u_wd
		(
			.clk(ref_clk),
			.rst_n(rst_sync_n),
			.tick(ms_tick),
			.run(enable_q && wd_en_q[i] && !seen[i]),
			.limit(wd_q),
			.expired(wd_exp[i])
		);
	end
	assign wd_live = |wd_exp;

	assign events = {sweep_done, dct_exp, retry_fail, fault_exp, wd_live};

	// register reads
	always_ff @(posedge ref_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			case (s_axi_araddr)
				ADDR_CTRL: s_axi_rdata <= {30'h0, auto_clear_q, enable_q};
				ADDR_PROBE: s_axi_rdata <= {12'h0, retry_q, gap_q, 1'b0,
					probe_addr_lim_q};
				ADDR_POLL_TO: s_axi_rdata <= {16'h0, poll_to_q};
				ADDR_DCT: s_axi_rdata <= {16'h0, dct_q};
				ADDR_MIN_INT: s_axi_rdata <= {16'h0, min_int_q};
				ADDR_WD: s_axi_rdata <= {16'h0, wd_q};
				ADDR_WD_EN: s_axi_rdata <= {24'h0, wd_en_q};
				ADDR_STATUS: s_axi_rdata <= {27'h0, status_q};
				ADDR_MASK: s_axi_rdata <= {27'h0, mask_q};
				ADDR_STATE: s_axi_rdata <= {2'h0, eff_int, 1'b0,
					probe_addr, state_q[1:0], tries_q[3:0]};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
	assign s_axi_arready = !s_axi_rvalid;

	////////////////////////////////////////////////////////////////////////
	// checks

	chk_probe_limit: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) probe_req |-> probe_addr <= probe_addr_lim_q)
		else $error("probe beyond limit");
	chk_gap_hold: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) sweep_done |=> !probe_req)
		else $error("probe during gap");
	chk_self_reset: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) master_reset |-> fault)
		else $error("reset without fault");
	chk_dct_auto: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) dct_exp |-> auto_clear_q)
		else $error("data control outside auto clear");
	chk_gap_wait: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) state_q == POLL_GAP && !gap_done
		|=> !poll_next)
		else $error("polled inside interval");
	chk_data_next: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) state_q == POLL_WAIT_ANS && poll_result.done
		&& poll_result.had_data && !poll_result.timeout && enable_q
		|=> poll_next)
		else $error("no immediate poll after data");
	chk_eff_int: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) eff_int >= slave_min_interval
		&& eff_int >= min_int_q)
		else $error("interval not raised");
	chk_wd_disable: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) wd_live |-> |(wd_exp & wd_en_q))
		else $error("disabled slave flagged");
	chk_retry_cap: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) poll_repeat |-> tries_q <= retry_q)
		else $error("too many repeats");
	chk_tick_spacing: assert property (@(posedge ref_clk) disable iff
		(!rst_sync_n) ms_tick |=> !ms_tick)
		else $error("tick too fast");
	cov_repeat: cover property (@(posedge ref_clk) poll_repeat);
	cov_gap: cover property (@(posedge ref_clk) state_q == POLL_GAP
		&& gap_done);
	cov_sweep: cover property (@(posedge ref_clk) sweep_done);

endmodule

// ### verilog/fieldbus_supervision_pkg.sv
package fieldbus_supervision_pkg;

	// clock and the 1 ms tick
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	// 0.1 ms sub-tick for the slave interval
	localparam int unsigned SUB_US = 100;
	localparam int unsigned SUB_CYCLES = CLK_HZ / 1_000_000 * SUB_US;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PROBE = 8'h04;
	localparam logic [7:0] ADDR_POLL_TO = 8'h08;
	localparam logic [7:0] ADDR_DCT = 8'h0C;
	localparam logic [7:0] ADDR_MIN_INT = 8'h10;
	localparam logic [7:0] ADDR_WD = 8'h14;
	localparam logic [7:0] ADDR_WD_EN = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1C;
	localparam logic [7:0] ADDR_MASK = 8'h20;
	localparam logic [7:0] ADDR_STATE = 8'h24;

	// reset values and limits
	localparam logic [15:0] POLL_TO_RST = 16'h01F4;
	localparam logic [15:0] DCT_RST = 16'h03E8;
	localparam logic [15:0] MIN_INT_RST = 16'h0014;
	localparam logic [15:0] WD_RST = 16'h00C8;
	localparam logic [6:0] PROBE_ADDR_RST = 7'h0A;
	localparam logic [6:0] PROBE_ADDR_MIN = 7'h02;
	localparam logic [6:0] PROBE_ADDR_MAX = 7'h7D;
	localparam logic [7:0] GAP_RST = 8'h0A;
	localparam logic [3:0] RETRY_RST = 4'h1;
	localparam logic [3:0] RETRY_MAX = 4'h8;
	localparam int unsigned NSLAVE = 8;

	// status bits
	localparam int unsigned ST_WD = 0;
	localparam int unsigned ST_SELF_RST = 1;
	localparam int unsigned ST_RETRY_FAIL = 2;
	localparam int unsigned ST_DCT = 3;
	localparam int unsigned ST_SWEEP = 4;
	localparam int unsigned NSTAT = 5;

	typedef enum logic [1:0]
	{
		POLL_IDLE = 2'b00,
		POLL_WAIT_ANS = 2'b01,
		POLL_GAP = 2'b11
	} poll_state_type;

	// report from the link engine about one finished poll
	typedef struct packed
	{
		logic done;
		logic had_data;
		logic timeout;
		logic [2:0] slave;
	} poll_result_type;

endpackage

// ### verilog/ms_timer.sv
`timescale 1ns/1ps
// counts ticks while run is high, flags when the limit is reached
module ms_timer
	import fieldbus_supervision_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic tick,
	input wire logic run,
	input wire logic [15:0] limit,
	// result
	output logic expired
);

	logic [15:0] count_q;

	// restart whenever run drops, saturate at the limit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count_q <= 16'h0000;
		else if (!run)
			count_q <= 16'h0000;
		else if (tick && count_q != limit)
			count_q <= count_q + 16'h0001;
	end

	assign expired = run && (count_q == limit);

endmodule

// ### verification/slave_stations.sv
`timescale 1ns/1ps
// stand-in for the slave stations behind the link engine
module slave_stations
	import fieldbus_supervision_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// requests from the master
	input wire logic poll_next,
	input wire logic poll_repeat,
	// 0 data, 1 no data, 2 no answer in time, 3 silent; lag in cycles
	input wire logic [1:0] mode,
	input wire logic [7:0] lag,
	// finished poll report
	output poll_result_type poll_result
);
	logic [7:0] wait_q;
	logic [2:0] slave_q;

	////////////////////////////////////////////////////////////////////////
	// answer after lag cycles; idle fields toggle so stale values never match
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_q <= 8'h00;
			slave_q <= 3'h0;
			poll_result <= '0;
		end
		else if (poll_next || poll_repeat)
		begin
			wait_q <= lag + 8'h01;
			slave_q <= slave_q + 3'(poll_next);
			poll_result <= {1'b0, ~poll_result[4:0]};
		end
		else if (wait_q == 8'h01 && mode != 2'h3)
		begin
			wait_q <= 8'h00;
			poll_result <= {1'b1, mode == 2'h0, mode == 2'h2, slave_q};
		end
		else
		begin
			wait_q <= wait_q - 8'(wait_q != 8'h00);
			poll_result <= {1'b0, ~poll_result[4:0]};
		end
	end
endmodule

// ### verification/fieldbus_master_poll_supervision_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) check(n, 32'(e), 32'(s))
module fieldbus_master_poll_supervision_bench
	import fieldbus_supervision_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	// answers are always accepted at the edge they are seen
	logic bready = 1'b1;
	logic arvalid = 1'b0;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	poll_result_type poll_result;
	logic token_pass = 1'b0;
	logic fault = 1'b0;
	logic [15:0] slave_min_interval = 16'h0001;
	logic poll_next, poll_repeat, probe_req, master_reset, irq;
	logic [6:0] probe_addr;
	logic [1:0] mode = 2'h3;
	logic [7:0] lag = 8'h02;
	logic [31:0] v;
	logic [1:0] r;
	int n;
	int cnt;
	int err_total = 0;
	int samples_checked = 0;

	// 25 ns period
	always #12.5 ref_clk = ~ref_clk;

	fieldbus_master_poll_supervision dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .poll_result(poll_result),
		.token_pass(token_pass), .fault(fault),
		.slave_min_interval(slave_min_interval), .poll_next(poll_next),
		.poll_repeat(poll_repeat), .probe_req(probe_req),
		.probe_addr(probe_addr), .master_reset(master_reset), .irq(irq));

	slave_stations far_u (.ref_clk(ref_clk), .rst_n(rst_n),
		.poll_next(poll_next), .poll_repeat(poll_repeat), .mode(mode),
		.lag(lag), .poll_result(poll_result));

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
	begin
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask

	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] s);
	begin
		samples_checked++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	end
	endtask

	// each valid holds until the rising edge that finds its ready high
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic hit_b;
		int k;
	begin
		k = 0;
		hit_b = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!hit_b && k < 200)
		begin
			@(posedge ref_clk);
			hit_b = bvalid;
			r = bresp;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			k++;
		end
		if (k >= 200)
		begin
			err_total++;
			end_sim();
		end
	end
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic hit_r;
		int k;
	begin
		k = 0;
		hit_r = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!hit_r && k < 200)
		begin
			@(posedge ref_clk);
			hit_r = rvalid;
			v = rdata;
			r = rresp;
			if (arvalid && arready)
				arvalid <= 1'b0;
			k++;
		end
		if (k >= 200)
		begin
			err_total++;
			end_sim();
		end
	end
	endtask

	// counts cycles up to the next pulse of poll_next
	task automatic wait_poll;
	begin
		n = 0;
		@(negedge ref_clk);
		while (poll_next !== 1'b1 && n < 20000)
		begin
			@(negedge ref_clk);
			n++;
		end
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
	begin
		`CHK("irq_rst", 1'b0, irq);
		axi_rd(ADDR_PROBE);
		`CHK("probe_rst", 32'h0001_0A0A, v);
		axi_rd(ADDR_POLL_TO);
		`CHK("poll_to_rst", 32'h0000_01F4, v);
		axi_rd(ADDR_DCT);
		`CHK("dct_rst", 32'h0000_03E8, v);
		axi_rd(ADDR_WD);
		`CHK("wd_rst", 32'h0000_00C8, v);
		axi_rd(ADDR_WD_EN);
		`CHK("wd_en_rst", 32'h0000_00FF, v);
		axi_rd(8'h28);
		`CHK("unmapped", 2'b10, r);
		axi_wr(8'h28, 32'h0000_0000);
		`CHK("wr_unmapped", 2'b10, r);
	end
	endtask

	// limit 1 clamps to 2, gap factor 1, retry limit 2
	task automatic t_probe;
		int hi;
	begin
		hi = 0;
		cnt = 0;
		// probing only runs while the master is enabled
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		axi_wr(ADDR_PROBE, 32'h0002_0101);
		`CHK("wr_okay", 2'b00, r);
		axi_rd(ADDR_PROBE);
		`CHK("probe_clamp", 32'h0002_0102, v);
		repeat (8)
		begin
			token_pass <= 1'b1;
			@(posedge ref_clk);
			token_pass <= 1'b0;
			repeat (3)
			begin
				@(negedge ref_clk);
				if (probe_req === 1'b1)
				begin
					cnt++;
					hi = (int'(probe_addr) > hi) ? int'(probe_addr) : hi;
				end
			end
			@(posedge ref_clk);
		end
		`CHK("probe_top", 2, hi);
		`CHK("probe_gap", 1'b1, cnt >= 2 && cnt < 8);
		axi_rd(ADDR_STATUS);
		`CHK("sweep_flag", 1'b1, v[ST_SWEEP]);
		// silent slaves leave polling stuck; disable to start clean
		axi_wr(ADDR_CTRL, 32'h0000_0000);
	end
	endtask

	// answers with data leave no spacing, however large the interval
	task automatic t_data;
	begin
		cnt = 0;
		mode <= 2'h0;
		slave_min_interval <= 16'h0003;
		axi_wr(ADDR_MIN_INT, 32'h0000_0001);
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		repeat (80)
		begin
			@(negedge ref_clk);
			cnt += int'(poll_next === 1'b1);
		end
		`CHK("data_polls", 1'b1, cnt >= 5);
		@(posedge ref_clk);
	end
	endtask

	// slow answers without data; slaves ask for 0.3 ms, register says 0.1
	task automatic t_gap;
	begin
		mode <= 2'h1;
		lag <= 8'h28;
		wait_poll();
		wait_poll();
		`CHK("gap_len", 1'b1, n >= 3 * SUB_CYCLES && n < 4 * SUB_CYCLES + 100);
		@(posedge ref_clk);
	end
	endtask

	task automatic t_retry;
	begin
		cnt = 0;
		n = 0;
		axi_wr(ADDR_MASK, 32'h0000_0004);
		mode <= 2'h2;
		lag <= 8'h04;
		while (irq !== 1'b1 && n < 40000)
		begin
			@(negedge ref_clk);
			cnt += int'(poll_repeat === 1'b1);
			n++;
		end
		`CHK("repeats", 2, cnt);
		// silence the slaves first, or the flag would be set again
		@(posedge ref_clk);
		mode <= 2'h3;
		axi_wr(ADDR_CTRL, 32'h0000_0000);
		axi_rd(ADDR_STATUS);
		`CHK("retry_flag", 1'b1, v[ST_RETRY_FAIL]);
		axi_wr(ADDR_STATUS, 32'h0000_0004);
		@(negedge ref_clk);
		`CHK("irq_clear", 1'b0, irq);
		@(posedge ref_clk);
	end
	endtask

	task automatic t_reset;
	begin
		axi_wr(ADDR_WD, 32'h0000_0001);
		axi_wr(ADDR_DCT, 32'h0000_0006);
		axi_wr(ADDR_WD_EN, 32'h0000_0000);
		// watchdogs only run while enabled; silent slaves never restart them
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		axi_wr(ADDR_POLL_TO, 32'h0000_0001);
		fault <= 1'b1;
		n = 0;
		while (master_reset !== 1'b1 && n < 80100)
		begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("reset_time", 1'b1, n >= 3 && n < 40100);
		@(posedge ref_clk);
		fault <= 1'b0;
		repeat (3) @(negedge ref_clk);
		`CHK("reset_drop", 1'b0, master_reset);
		@(posedge ref_clk);
		axi_rd(ADDR_STATUS);
		`CHK("self_rst_flag", 1'b1, v[ST_SELF_RST]);
		`CHK("wd_off_flag", 1'b0, v[ST_WD]);
		// a second reset in mid-run
		rst_n <= 1'b0;
		@(negedge ref_clk);
		`CHK("rst_outs", 4'h0, {master_reset, poll_next, probe_req, irq});
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		axi_rd(ADDR_POLL_TO);
		`CHK("poll_to_clr", 32'h0000_01F4, v);
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	// the millisecond waits make a run of under 2 ms; 2.5 ms means a hang
	initial
	begin
		#2_500_000;
		err_total++;
		end_sim();
	end

	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_probe();
		t_data();
		t_gap();
		t_retry();
		t_reset();
		end_sim();
	end
endmodule
